// ### tgsc_pkg.sv
package tgsc_pkg;
	// ****************************************
	// status word layout
	// ****************************************
	localparam int STATUS_W = 32;
	localparam int ERRCNT_MSB = 31;
	localparam int ERRCNT_LSB = 16;
	localparam int ERRCNT_W = 16;
	localparam int IDX_MSB = 9;
	localparam int IDX_LSB = 2;
	localparam int IDX_W = 8;
	localparam int RES_W = 2;
	localparam logic [1:0] RES_NONE = 2'h0;
	localparam logic [1:0] RES_PASS = 2'h1;
	localparam logic [1:0] RES_FAIL = 2'h2;
	localparam logic [1:0] RES_HANG = 2'h3;
	// ****************************************
	// register port
	// ****************************************
	localparam int ADDR_W = 4;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_ERR_EN = 4'h8;
	localparam logic [3:0] REG_RETRY = 4'hC;
	localparam int CTRL_SYSINIT_BIT = 0;
	localparam int CTRL_LITE_SEQ_BIT = 1;
	localparam logic [7:0] RETRY_RST = 8'h04;
	localparam logic [7:0] ENTRIES_RST = 8'h10;
	localparam int HANG_TIME_NS = 10000;
	localparam int CLK_NS = 10;
	localparam int HANG_CYC = HANG_TIME_NS / CLK_NS;
	localparam int HANG_W = 16;
endpackage

// ### tgsc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module tgsc_sync
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// pin in, qualified pulse out
	input wire logic d_i,
	output logic rise_o
);
	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic lvl_ff;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
			lvl_ff <= 1'b0;
		end
		else
		begin
			s1_ff <= d_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff)
				lvl_ff <= s3_ff;
		end
	end

	// one pulse per agreed rising level
	assign rise_o = (s2_ff == s3_ff) && s3_ff && !lvl_ff;
endmodule // tgsc_sync
`default_nettype wire

// ### tgsc_top.sv
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - the completion interrupt output rises once generation of the entry list has finished.
// - in lightweight-bus sequence operation the done flag marks the end of the whole sequence.
// - a 32-bit status output reports the outcome of init and test operation.
// - status bits 31:16 count errors seen during generation and bits 15:10 read zero.
// - status bits 9:2 show the entry index being processed, advancing with each entry.
// - a failing entry is reissued up to a retry limit, then the run stops with the index kept.
// - status bits 1:0 give 01 pass, 10 fail, 11 hang, and 00 is no result, which a run ended by stop keeps.
// - a start pulse begins traffic generation.
// - a stop pulse ends traffic generation.
// - in init operation the read channel of the lightweight master is never used.
// - start and stop alone control the block, with no processor needed.
module tgsc_top
#(
	parameter int HANG_CYCLES = tgsc_pkg::HANG_CYC
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// system control pins
	input wire logic ext_start_i,
	input wire logic ext_stop_i,
	// entry engine handshake
	input wire logic entry_ack_i,
	input wire logic entry_err_i,
	output logic entry_issue_o,
	output logic rd_chan_en_o,
	// register port
	input wire logic [3:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// system outputs
	output logic irq_o,
	output logic err_o,
	output logic done_o,
	output logic [31:0] status_o
);
	typedef enum {TGSC_IDLE, TGSC_ISSUE, TGSC_WAIT, TGSC_END} tgsc_state_t;

	logic rst_a_ff;
	logic rst_ff;
	logic start_p;
	logic stop_p;
	tgsc_state_t state_ff;
	logic [7:0] idx_ff;
	logic [7:0] retry_ff;
	logic [15:0] errcnt_ff;
	logic [1:0] res_ff;
	logic [15:0] hang_ff;
	logic [1:0] ctrl_ff;
	logic err_en_ff;
	logic [7:0] retry_max_ff;
	logic [7:0] entries_ff;
	logic fin;
	logic [1:0] fin_res;
	logic [31:0] stat_w;
	logic fin_ff;

	// ****************************************
	// reset release
	// ****************************************
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rst_a_ff <= 1'b0;
			rst_ff <= 1'b0;
		end
		else
		begin
			rst_a_ff <= 1'b1;
			rst_ff <= rst_a_ff;
		end
	end

	tgsc_sync u_start
	(
		.clk_i(clk_i),
		.rst_n_i(rst_ff),
		.d_i(ext_start_i),
		.rise_o(start_p)
	);

	tgsc_sync u_stop
	(
		.clk_i(clk_i),
		.rst_n_i(rst_ff),
		.d_i(ext_stop_i),
		.rise_o(stop_p)
	);

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clk_i or negedge rst_ff)
	begin
		if (!rst_ff)
		begin
			ctrl_ff <= 2'h0;
			err_en_ff <= 1'b0;
			retry_max_ff <= tgsc_pkg::RETRY_RST;
			entries_ff <= tgsc_pkg::ENTRIES_RST;
		end
		else if (reg_wr_i)
		begin
			case (reg_addr_i)
				tgsc_pkg::REG_CTRL: ctrl_ff <= reg_wdata_i[1:0];
				tgsc_pkg::REG_ERR_EN: err_en_ff <= reg_wdata_i[0];
				tgsc_pkg::REG_RETRY:
				begin
					retry_max_ff <= reg_wdata_i[7:0];
					entries_ff <= reg_wdata_i[15:8];
				end
				default: ;
			endcase
		end
	end

	// reserved status bits stay zero
	assign stat_w = {errcnt_ff, 6'h00, idx_ff, res_ff};

	always_ff @(posedge clk_i or negedge rst_ff)
	begin
		if (!rst_ff)
			reg_rdata_o <= 32'h0;
		else if (reg_rd_i)
		begin
			case (reg_addr_i)
				tgsc_pkg::REG_CTRL: reg_rdata_o <= {30'h0, ctrl_ff};
				tgsc_pkg::REG_STATUS: reg_rdata_o <= stat_w;
				tgsc_pkg::REG_ERR_EN: reg_rdata_o <= {31'h0, err_en_ff};
				tgsc_pkg::REG_RETRY: reg_rdata_o <= {16'h0, entries_ff, retry_max_ff};
				default: reg_rdata_o <= 32'h0;
			endcase
		end
		else
			reg_rdata_o <= 32'h0;
	end

	// ****************************************
	// sequencer
	// ****************************************
	// end of run: last entry acked, retries spent, or watchdog
	always_comb
	begin
		fin = 1'b0;
		fin_res = tgsc_pkg::RES_PASS;
		if (state_ff == TGSC_WAIT)
		begin
			if (hang_ff == 16'(HANG_CYCLES - 1))
			begin
				fin = 1'b1;
				fin_res = tgsc_pkg::RES_HANG;
			end
			else if (entry_ack_i && entry_err_i && retry_ff == retry_max_ff)
			begin
				fin = 1'b1;
				fin_res = tgsc_pkg::RES_FAIL;
			end
			else if (entry_ack_i && !entry_err_i && idx_ff == entries_ff - 8'h01)
				fin = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_ff)
	begin
		if (!rst_ff)
		begin
			state_ff <= TGSC_IDLE;
			idx_ff <= 8'h00;
			retry_ff <= 8'h00;
			errcnt_ff <= 16'h0;
			res_ff <= tgsc_pkg::RES_NONE;
			hang_ff <= 16'h0;
		end
		else if (stop_p && state_ff != TGSC_IDLE && state_ff != TGSC_END)
			state_ff <= TGSC_END;
		else
		begin
			case (state_ff)
				TGSC_IDLE, TGSC_END:
					if (start_p)
					begin
						state_ff <= TGSC_ISSUE;
						idx_ff <= 8'h00;
						retry_ff <= 8'h00;
						errcnt_ff <= 16'h0;
						res_ff <= tgsc_pkg::RES_NONE;
					end
				TGSC_ISSUE:
				begin
					hang_ff <= 16'h0;
					state_ff <= TGSC_WAIT;
				end
				TGSC_WAIT:
				begin
					hang_ff <= hang_ff + 16'h1;
					if (entry_ack_i && entry_err_i && errcnt_ff != 16'hFFFF)
						errcnt_ff <= errcnt_ff + 16'h1;
					if (fin)
					begin
						res_ff <= fin_res;
						state_ff <= TGSC_END;
					end
					else if (entry_ack_i)
					begin
						state_ff <= TGSC_ISSUE;
						if (entry_err_i)
							retry_ff <= retry_ff + 8'h01;
						else
						begin
							retry_ff <= 8'h00;
							idx_ff <= idx_ff + 8'h01;
						end
					end
				end
				default: state_ff <= TGSC_IDLE;
			endcase
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	always_ff @(posedge clk_i or negedge rst_ff)
	begin
		if (!rst_ff)
		begin
			entry_issue_o <= 1'b0;
			rd_chan_en_o <= 1'b0;
			irq_o <= 1'b0;
			err_o <= 1'b0;
			done_o <= 1'b0;
			status_o <= 32'h0;
			fin_ff <= 1'b0;
		end
		else
		begin
			entry_issue_o <= (state_ff == TGSC_ISSUE);
			rd_chan_en_o <= !ctrl_ff[tgsc_pkg::CTRL_SYSINIT_BIT];
			// completion shows one cycle late so that status already carries the result
			fin_ff <= (state_ff == TGSC_WAIT) && fin && !stop_p;
			irq_o <= fin_ff;
			err_o <= err_en_ff && (state_ff == TGSC_WAIT) && entry_ack_i && entry_err_i && !stop_p;
			if (fin_ff && ctrl_ff[tgsc_pkg::CTRL_LITE_SEQ_BIT])
				done_o <= 1'b1;
			else if (start_p)
				done_o <= 1'b0;
			status_o <= stat_w;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	property p_res_nonzero;
		@(posedge clk_i) disable iff (!rst_ff)
		$rose(irq_o) |-> status_o[1:0] != 2'h0;
	endproperty
	a_res_nonzero: assert property (p_res_nonzero) else $error("no result at completion");

	property p_reserved_zero;
		@(posedge clk_i) disable iff (!rst_ff)
		status_o[15:10] == 6'h00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved status bits set");

	property p_irq_pulse;
		@(posedge clk_i) disable iff (!rst_ff)
		irq_o |=> !irq_o;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than one cycle");

	property p_stop_ends;
		@(posedge clk_i) disable iff (!rst_ff)
		stop_p && state_ff == TGSC_WAIT |=> state_ff == TGSC_END;
	endproperty
	a_stop_ends: assert property (p_stop_ends) else $error("stop did not end run");

	property p_start_runs;
		@(posedge clk_i) disable iff (!rst_ff)
		start_p && state_ff == TGSC_IDLE |=> ##1 entry_issue_o;
	endproperty
	a_start_runs: assert property (p_start_runs) else $error("start did not issue");

	property p_fail_keeps_idx;
		@(posedge clk_i) disable iff (!rst_ff)
		state_ff == TGSC_WAIT && fin && fin_res == tgsc_pkg::RES_FAIL |=> ##1 status_o[9:2] == $past(idx_ff, 2);
	endproperty
	a_fail_keeps_idx: assert property (p_fail_keeps_idx) else $error("index lost on fail");

	property p_done_status;
		@(posedge clk_i) disable iff (!rst_ff)
		$rose(done_o) |-> irq_o && status_o[1:0] != 2'h0;
	endproperty
	a_done_status: assert property (p_done_status) else $error("done without result");

	property p_err_count;
		@(posedge clk_i) disable iff (!rst_ff)
		err_o |-> ##1 status_o[31:16] == $past(status_o[31:16]) + 16'h1 || status_o[31:16] == 16'hFFFF;
	endproperty
	a_err_count: assert property (p_err_count) else $error("error not counted");

	property p_init_no_read;
		@(posedge clk_i) disable iff (!rst_ff)
		ctrl_ff[0] |=> !rd_chan_en_o;
	endproperty
	a_init_no_read: assert property (p_init_no_read) else $error("read channel used in init");
endmodule // tgsc_top
`default_nettype wire

// ### tgsc_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module tgsc_engine_model
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// entry handshake
	input wire logic issue_i,
	input wire logic [7:0] idx_i,
	output logic ack_o,
	output logic err_o,
	// behaviour
	input wire logic mute_i,
	input wire logic fail_en_i,
	input wire logic [7:0] fail_idx_i,
	input wire logic [3:0] delay_i
);
	logic busy_ff;
	logic [3:0] cnt_ff;
	// err toggles while no ack qualifies it
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			busy_ff <= 1'b0;
			cnt_ff <= 4'h0;
			ack_o <= 1'b0;
			err_o <= 1'b0;
		end
		else
		begin
			ack_o <= 1'b0;
			err_o <= ~err_o;
			if (issue_i && !mute_i)
			begin
				busy_ff <= 1'b1;
				cnt_ff <= delay_i;
			end
			else if (busy_ff && cnt_ff == 4'h0)
			begin
				busy_ff <= 1'b0;
				ack_o <= 1'b1;
				err_o <= fail_en_i && idx_i == fail_idx_i;
			end
			else if (busy_ff)
				cnt_ff <= cnt_ff - 4'h1;
		end
	end
endmodule // tgsc_engine_model
`default_nettype wire

// ### tgsc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fail_count++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end
module tgsc_top_test;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic ext_start_i = 1'b0;
	logic ext_stop_i = 1'b0;
	logic entry_ack_i, entry_err_i, entry_issue_o, rd_chan_en_o, irq_o, err_o, done_o;
	logic [3:0] reg_addr_i = 4'h0;
	logic [31:0] reg_wdata_i = 32'h0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [31:0] reg_rdata_o, status_o, v;
	logic m_mute = 1'b0;
	logic m_fail = 1'b0;
	logic [7:0] m_fidx = 8'h00;
	logic [3:0] m_dly = 4'h0;
	int fail_count = 0;
	int checks_done = 0;
	int issues, errs, irqs, good, w;
	always #5 clk_i = ~clk_i;
	tgsc_top #(.HANG_CYCLES(20)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ext_start_i(ext_start_i),
		.ext_stop_i(ext_stop_i), .entry_ack_i(entry_ack_i), .entry_err_i(entry_err_i),
		.entry_issue_o(entry_issue_o), .rd_chan_en_o(rd_chan_en_o), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.irq_o(irq_o), .err_o(err_o), .done_o(done_o), .status_o(status_o));
	tgsc_engine_model i_eng (.clk_i(clk_i), .rst_n_i(rst_n_i), .issue_i(entry_issue_o), .idx_i(status_o[9:2]),
		.ack_o(entry_ack_i), .err_o(entry_err_i), .mute_i(m_mute), .fail_en_i(m_fail),
		.fail_idx_i(m_fidx), .delay_i(m_dly));
	// ****************************************
	// event counters
	// ****************************************
	always @(posedge clk_i)
	begin
		if (entry_issue_o === 1'b1)
		begin
			`CHK(status_o[9:2], 8'(good))
			issues++;
		end
		if (entry_ack_i === 1'b1 && entry_err_i === 1'b0)
			good++;
		if (err_o === 1'b1)
			errs++;
		if (irq_o === 1'b1)
			irqs++;
	end
	// ****************************************
	// bus and pin tasks
	// ****************************************
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic chk_rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1;
		v = reg_rdata_o;
		`CHK(v, e)
	endtask
	// pins are held three cycles so that two synchroniser stages can agree
	task automatic pulse_pin(input logic stop);
		@(posedge clk_i);
		if (stop)
			ext_stop_i <= 1'b1;
		else
			ext_start_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		ext_start_i <= 1'b0;
		ext_stop_i <= 1'b0;
	endtask
	task automatic start_run;
		@(negedge clk_i);
		issues = 0;
		errs = 0;
		irqs = 0;
		good = 0;
		pulse_pin(1'b0);
	endtask
	// ****************************************
	// one run: pass, fail or hang
	// ****************************************
	task automatic run(input logic [7:0] n, input logic fail, input logic mute, input logic lite);
		logic [7:0] rmax;
		logic sys;
		logic en;
		rmax = 8'($urandom_range(1, 3));
		sys = 1'($urandom);
		en = 1'($urandom);
		m_fail <= fail;
		m_mute <= mute;
		m_fidx <= 8'($urandom_range(0, n - 1));
		m_dly <= 4'($urandom_range(0, 4));
		wr(tgsc_pkg::REG_RETRY, {16'h0000, n, rmax});
		wr(tgsc_pkg::REG_CTRL, {30'h0, lite, sys});
		wr(tgsc_pkg::REG_ERR_EN, {31'h0, en});
		`CHK(rd_chan_en_o, !sys)
		start_run();
		for (w = 0; w < 2000 && irq_o !== 1'b1; w++)
			@(posedge clk_i) #1;
		`CHK(irq_o, 1'b1)
		`CHK(done_o, lite)
		// status is only looked at while done stands
		if (lite)
		begin
			`CHK(status_o[15:10], 6'h00)
			if (mute)
			begin
				`CHK(status_o[1:0], tgsc_pkg::RES_HANG)
				`CHK(status_o[9:2], 8'h00)
			end
			else if (fail)
			begin
				`CHK(status_o[1:0], tgsc_pkg::RES_FAIL)
				`CHK(status_o[9:2], m_fidx)
				`CHK(status_o[31:16], 16'(issues) - 16'(m_fidx))
				`CHK(16'(errs), en ? 16'(issues) - 16'(m_fidx) : 16'h0000)
			end
			else
			begin
				`CHK(status_o[1:0], tgsc_pkg::RES_PASS)
				`CHK(8'(issues), n)
				`CHK(status_o[9:2], n - 8'h01)
				`CHK(status_o[31:16], 16'h0000)
			end
		end
		@(posedge clk_i) #1;
		`CHK(irq_o, 1'b0)
	endtask
	task automatic give_verdict;
		$display("checks %0d failures %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		#200000;
		fail_count++;
		give_verdict();
	end
	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		void'($urandom(67323));
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		`CHK({irq_o, err_o, done_o, status_o}, 35'h0)
		chk_rd(tgsc_pkg::REG_RETRY, {16'h0000, tgsc_pkg::ENTRIES_RST, tgsc_pkg::RETRY_RST});
		chk_rd(tgsc_pkg::REG_CTRL, 32'h0);
		chk_rd(tgsc_pkg::REG_ERR_EN, 32'h0);
		wr(4'h2, 32'hFFFF_FFFF);
		chk_rd(4'h2, 32'h0);
		run(8'h02, 1'b0, 1'b0, 1'b1);
		run(8'h02, 1'b0, 1'b0, 1'b0);
		repeat (3) run(8'($urandom_range(2, 6)), 1'b0, 1'b0, 1'b1);
		repeat (3) run(8'($urandom_range(2, 6)), 1'b1, 1'b0, 1'b1);
		run(8'h03, 1'b0, 1'b1, 1'b1);
		// stop while the first entry is still outstanding
		m_mute <= 1'b0;
		m_dly <= 4'hF;
		start_run();
		for (w = 0; w < 50 && issues == 0; w++)
			@(posedge clk_i) #1;
		pulse_pin(1'b1);
		repeat (40) @(posedge clk_i);
		#1;
		`CHK(8'(issues), 8'h01)
		`CHK(8'(irqs), 8'h00)
		`CHK(done_o, 1'b0)
		// start cleared the result, and a stop reports none
		chk_rd(tgsc_pkg::REG_STATUS, 32'h0);
		// reset in mid-run clears everything at once
		start_run();
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b0;
		#1;
		`CHK({irq_o, done_o, status_o}, 34'h0)
		@(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk_rd(tgsc_pkg::REG_RETRY, {16'h0000, tgsc_pkg::ENTRIES_RST, tgsc_pkg::RETRY_RST});
		give_verdict();
	end
endmodule // tgsc_top_test
`default_nettype wire
